// ---- design/ihc_pkg.sv ----
// constants, register map and types of the histogram control
package ihc_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] IHC_OFF_CTRL = 12'h000; // unit_control_reg (shadowed)
    localparam logic [11:0] IHC_OFF_CFG = 12'h004; // hist_config_reg
    localparam logic [11:0] IHC_OFF_GAIN = 12'h008; // white_balance_gains
    localparam logic [11:0] IHC_OFF_RGN = 12'h00C; // region0_horizontal, then vertical, region1 ...
    localparam logic [11:0] IHC_OFF_RADDR = 12'h02C; // input_read_address (shadowed)
    localparam logic [11:0] IHC_OFF_LOFF = 12'h030; // input_line_offset (shadowed)
    localparam logic [11:0] IHC_OFF_FSIZE = 12'h034; // input_frame_size
    localparam logic [1:0] IHC_BIN_WIN = 2'h1; // paddr[11:10] of the bin_memory_port window

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int IHC_CTRL_EN_BIT = 0;
    localparam int IHC_CTRL_BUSY_BIT = 1;
    localparam int IHC_CFG_SRC_BIT = 0; // 1 = external memory, 0 = video port
    localparam int IHC_CFG_CFA_LSB = 1; // colour_pattern_sel, 2 bits
    localparam int IHC_CFG_BINS_LSB = 3; // bin count code, 2 bits
    localparam int IHC_CFG_SHIFT_LSB = 5; // shift amount, 4 bits
    localparam int IHC_CFG_CAR_BIT = 9; // clear_after_read
    localparam int IHC_CFG_PW_BIT = 10; // input_pixel_width: 1 = 8-bit, 0 = 16-bit
    localparam int IHC_CFG_W = 11;

    // ------------------------------------------------------------------
    // reset values and sizes
    // ------------------------------------------------------------------
    localparam logic [31:0] IHC_RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] IHC_RST_GAIN = 32'h2020_2020; // unity gain in every position
    localparam int IHC_GAIN_FRAC = 5;
    localparam int IHC_NUM_RGN = 4;
    localparam int IHC_NUM_BANK = 4;
    localparam int IHC_BANK_AW = 6;
    localparam int IHC_BIN_AW = 8;
    localparam int IHC_CNT_W = 20;
    localparam int IHC_PIX_W = 16;
    localparam int IHC_MIN_BINS_LOG = 5; // code 0 = 32 bins
    localparam logic [1:0] IHC_DRAIN_CYC = 2'h3; // edges from last pixel taken to frame interrupt, one after the last bin update

    typedef enum logic [1:0] {
        IHC_ST_IDLE = 2'b00,
        IHC_ST_FETCH = 2'b01,
        IHC_ST_STREAM = 2'b10,
        IHC_ST_DRAIN = 2'b11
    } ihc_state_t;

endpackage

// ---- design/ihc_bin_if.sv ----
// control to bin-counter memory carrier
`timescale 1ns/1ps
interface ihc_bin_if;
    import ihc_pkg::*;
    logic [IHC_NUM_RGN-1:0] acc_hit;
    logic [IHC_NUM_RGN-1:0][IHC_BIN_AW-1:0] acc_addr;
    logic [IHC_BIN_AW-1:0] cpu_addr;
    logic cpu_wr;
    logic cpu_clr;
    logic [IHC_CNT_W-1:0] cpu_wdata;
    logic [IHC_CNT_W-1:0] cpu_rdata;

    modport ctrl (output acc_hit, acc_addr, cpu_addr, cpu_wr, cpu_clr, cpu_wdata, input cpu_rdata);
    modport mem (input acc_hit, acc_addr, cpu_addr, cpu_wr, cpu_clr, cpu_wdata, output cpu_rdata);
endinterface

// ---- design/ihc_bin_mem.sv ----
// banked bin-counter memory, per-region increment
`timescale 1ns/1ps
module ihc_bin_mem
    import ihc_pkg::*;
(
    input wire logic i_clk_sys,
    ihc_bin_if.mem bin
);

    logic [IHC_NUM_BANK-1:0][IHC_CNT_W-1:0] bank_rd;

    // ------------------------------------------------------------------
    // one bank per quarter of the address space; regions never share a bank
    // ------------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < IHC_NUM_BANK; k++)
        begin : g_bank
            // no reset on purpose: counts survive a subsystem reset
            logic [IHC_CNT_W-1:0] mem_ff [2**IHC_BANK_AW];
            logic acc_en;
            logic [IHC_BANK_AW-1:0] acc_word;
            logic cpu_hit;

            // pick the region that lands in this bank
            always_comb
            begin
                acc_en = 1'b0;
                acc_word = '0;
                for (int r = 0; r < IHC_NUM_RGN; r++)
                begin
                    if (bin.acc_hit[r] && (bin.acc_addr[r][IHC_BIN_AW-1:IHC_BANK_AW] == 2'(k)))
                    begin
                        acc_en = 1'b1;
                        acc_word = bin.acc_addr[r][IHC_BANK_AW-1:0];
                    end
                end
                cpu_hit = (bin.cpu_addr[IHC_BIN_AW-1:IHC_BANK_AW] == 2'(k));
            end

            // saturating increment; processor port locked out while counting
            always_ff @(posedge i_clk_sys)
            begin
                if (acc_en && (mem_ff[acc_word] != {IHC_CNT_W{1'b1}}))
                    mem_ff[acc_word] <= mem_ff[acc_word] + 1'b1;
                else if (cpu_hit && bin.cpu_clr)
                    mem_ff[bin.cpu_addr[IHC_BANK_AW-1:0]] <= '0;
                else if (cpu_hit && bin.cpu_wr)
                    mem_ff[bin.cpu_addr[IHC_BANK_AW-1:0]] <= bin.cpu_wdata;
            end

            assign bank_rd[k] = mem_ff[bin.cpu_addr[IHC_BANK_AW-1:0]];
        end
    endgenerate

    assign bin.cpu_rdata = bank_rd[bin.cpu_addr[IHC_BIN_AW-1:IHC_BANK_AW]];

endmodule // ihc_bin_mem

// ---- design/ihc_hist_ctrl.sv ----
// histogram unit control: apb registers, frame sequencing, pixel pipeline
// Behaviour
// - subsystem reset restores all configuration registers
// - bin memory keeps content across subsystem reset
// - clear-after-read zeroes a bin once read
// - bin memory access blocked while busy
// - memory source: one frame, enable self-clears
// - video source: continuous, follows port frame timing
// - video disable takes effect at frame end
// - one interrupt and DMA event per frame
// - busy set at frame start if enabled
// - busy clears with DMA event when safe
// - interrupt only after last bin update lands
// - shadowed registers apply at next frame start
// - only control, read address, offset shadowed
// - busy-locked writes ignored while busy, no error
// - bin reads while busy indeterminate, whole words
// - bins accumulate across frames until cleared
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module ihc_hist_ctrl
    import ihc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_vp_sof,
    input wire logic i_vp_eol,
    input wire logic i_vp_eof,
    input wire logic i_vp_valid,
    input wire logic [IHC_PIX_W-1:0] i_vp_data,
    output logic o_mem_rd_req,
    output logic [31:0] o_mem_rd_addr,
    input wire logic i_mem_rd_valid,
    input wire logic [IHC_PIX_W-1:0] i_mem_rd_data,
    output logic o_busy,
    output logic o_dma_event,
    output logic o_frame_irq
);

    ihc_bin_if bin ();

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic apb_setup;
    logic apb_wr;
    logic bin_sel;
    logic bin_block;
    logic car_read;
    assign apb_setup = i_psel & ~i_penable;
    assign apb_wr = i_psel & i_penable & i_pwrite;
    assign bin_sel = (i_paddr[11:10] == IHC_BIN_WIN);
    assign o_pready = i_penable; // zero wait states
    assign o_pslverr = 1'b0; // locked writes still complete cleanly

    // ------------------------------------------------------------------
    // register and sequencer state
    // ------------------------------------------------------------------
    ihc_state_t state_ff, nxt_state;
    logic en_ff, nxt_en;
    logic busy_ff, nxt_busy;
    logic [IHC_CFG_W-1:0] cfg_ff, nxt_cfg;
    logic [31:0] gain_ff, nxt_gain;
    logic [2*IHC_NUM_RGN-1:0][31:0] rgn_ff, nxt_rgn;
    logic [31:0] raddr_ff, nxt_raddr;
    logic [31:0] loff_ff, nxt_loff;
    logic [31:0] fsize_ff, nxt_fsize;
    logic [31:0] act_loff_ff, nxt_act_loff;
    logic [31:0] line_base_ff, nxt_line_base;
    logic [31:0] rd_addr_ff, nxt_rd_addr;
    logic req_ff, nxt_req;
    logic [15:0] x_ff, nxt_x;
    logic [15:0] y_ff, nxt_y;
    logic [1:0] drain_ff, nxt_drain;
    logic dma_ff, nxt_dma;
    logic irq_ff, nxt_irq;
    logic [31:0] prdata_ff, nxt_prdata;
    logic start_mem;
    logic start_vid;
    logic last_px;
    logic [31:0] step;

    assign bin_block = busy_ff | (state_ff == IHC_ST_DRAIN);
    // memory mode starts at once, video mode waits for sof
    assign start_mem = (state_ff == IHC_ST_IDLE) & en_ff & cfg_ff[IHC_CFG_SRC_BIT];
    assign start_vid = (state_ff == IHC_ST_IDLE) & en_ff & ~cfg_ff[IHC_CFG_SRC_BIT] & i_vp_sof;
    assign last_px = (x_ff == fsize_ff[15:0] - 16'h0001) && (y_ff == fsize_ff[31:16] - 16'h0001);
    assign step = cfg_ff[IHC_CFG_PW_BIT] ? 32'h0000_0001 : 32'h0000_0002;
    assign car_read = i_psel & i_penable & ~i_pwrite & bin_sel & ~bin_block & cfg_ff[IHC_CFG_CAR_BIT];

    // software writes, frame start and end, and the read data register
    always_comb
    begin
        nxt_state = state_ff;
        nxt_en = en_ff;
        nxt_busy = busy_ff;
        nxt_cfg = cfg_ff;
        nxt_gain = gain_ff;
        nxt_rgn = rgn_ff;
        nxt_raddr = raddr_ff;
        nxt_loff = loff_ff;
        nxt_fsize = fsize_ff;
        nxt_act_loff = act_loff_ff;
        nxt_line_base = line_base_ff;
        nxt_rd_addr = rd_addr_ff;
        nxt_req = req_ff;
        nxt_x = x_ff;
        nxt_y = y_ff;
        nxt_drain = drain_ff;
        nxt_dma = 1'b0;
        nxt_irq = 1'b0;
        nxt_prdata = prdata_ff;

        // shadowed registers take writes at any time
        if (apb_wr && (i_paddr == IHC_OFF_CTRL))
            nxt_en = i_pwdata[IHC_CTRL_EN_BIT];
        if (apb_wr && (i_paddr == IHC_OFF_RADDR))
            nxt_raddr = i_pwdata;
        if (apb_wr && (i_paddr == IHC_OFF_LOFF))
            nxt_loff = i_pwdata;
        // busy-locked registers ignore writes while busy
        if (apb_wr && !busy_ff)
        begin
            if (i_paddr == IHC_OFF_CFG)
                nxt_cfg = i_pwdata[IHC_CFG_W-1:0];
            if (i_paddr == IHC_OFF_GAIN)
                nxt_gain = i_pwdata;
            if (i_paddr == IHC_OFF_FSIZE)
                nxt_fsize = i_pwdata;
            for (int i = 0; i < 2 * IHC_NUM_RGN; i++)
                if (i_paddr == IHC_OFF_RGN + 12'(4 * i))
                    nxt_rgn[i] = i_pwdata;
        end

        case (state_ff)
            IHC_ST_IDLE:
            begin
                if (start_mem)
                begin
                    nxt_en = 1'b0;
                    nxt_busy = 1'b1;
                    nxt_state = IHC_ST_FETCH;
                    nxt_act_loff = loff_ff;
                    nxt_line_base = raddr_ff;
                    nxt_rd_addr = raddr_ff;
                    nxt_req = 1'b1;
                    nxt_x = '0;
                    nxt_y = '0;
                end
                else if (start_vid)
                begin
                    nxt_busy = 1'b1;
                    nxt_state = IHC_ST_STREAM;
                    nxt_x = '0;
                    nxt_y = '0;
                end
            end
            IHC_ST_FETCH:
            begin
                if (i_mem_rd_valid)
                begin
                    if (last_px)
                    begin
                        nxt_req = 1'b0;
                        nxt_busy = 1'b0;
                        nxt_dma = 1'b1;
                        nxt_drain = IHC_DRAIN_CYC - 2'h1;
                        nxt_state = IHC_ST_DRAIN;
                    end
                    else if (x_ff == fsize_ff[15:0] - 16'h0001)
                    begin
                        nxt_x = '0;
                        nxt_y = y_ff + 16'h0001;
                        nxt_line_base = line_base_ff + act_loff_ff;
                        nxt_rd_addr = line_base_ff + act_loff_ff;
                    end
                    else
                    begin
                        nxt_x = x_ff + 16'h0001;
                        nxt_rd_addr = rd_addr_ff + step;
                    end
                end
            end
            IHC_ST_STREAM:
            begin
                // a mid-frame disable waits for the frame end
                if (i_vp_eof)
                begin
                    nxt_busy = 1'b0;
                    nxt_dma = 1'b1;
                    nxt_drain = IHC_DRAIN_CYC - 2'h1;
                    nxt_state = IHC_ST_DRAIN;
                end
                else if (i_vp_eol)
                begin
                    nxt_x = '0;
                    nxt_y = y_ff + 16'h0001;
                end
                else if (i_vp_valid)
                    nxt_x = x_ff + 16'h0001;
            end
            IHC_ST_DRAIN:
            begin
                // irq waits for the last increment to land
                if (drain_ff == 2'h0)
                begin
                    nxt_irq = 1'b1;
                    nxt_state = IHC_ST_IDLE;
                end
                else
                    nxt_drain = drain_ff - 2'h1;
            end
            default:
                nxt_state = IHC_ST_IDLE;
        endcase

        // read data captured in setup, answered in access
        if (apb_setup && !i_pwrite)
        begin
            nxt_prdata = '0;
            if (bin_sel)
                nxt_prdata = bin_block ? '0 : 32'(bin.cpu_rdata);
            else
            begin
                case (i_paddr)
                    IHC_OFF_CTRL: nxt_prdata = {30'h0, busy_ff, en_ff};
                    IHC_OFF_CFG: nxt_prdata = 32'(cfg_ff);
                    IHC_OFF_GAIN: nxt_prdata = gain_ff;
                    IHC_OFF_RADDR: nxt_prdata = raddr_ff;
                    IHC_OFF_LOFF: nxt_prdata = loff_ff;
                    IHC_OFF_FSIZE: nxt_prdata = fsize_ff;
                    default:
                    begin
                        for (int i = 0; i < 2 * IHC_NUM_RGN; i++)
                            if (i_paddr == IHC_OFF_RGN + 12'(4 * i))
                                nxt_prdata = rgn_ff[i];
                    end
                endcase
            end
        end
    end

    // register stage of the control state
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_ff <= IHC_ST_IDLE;
            en_ff <= 1'b0;
            busy_ff <= 1'b0;
            cfg_ff <= '0;
            gain_ff <= IHC_RST_GAIN;
            rgn_ff <= '0;
            raddr_ff <= IHC_RST_ZERO;
            loff_ff <= IHC_RST_ZERO;
            fsize_ff <= IHC_RST_ZERO;
            act_loff_ff <= IHC_RST_ZERO;
            line_base_ff <= IHC_RST_ZERO;
            rd_addr_ff <= IHC_RST_ZERO;
            req_ff <= 1'b0;
            x_ff <= '0;
            y_ff <= '0;
            drain_ff <= '0;
            dma_ff <= 1'b0;
            irq_ff <= 1'b0;
            prdata_ff <= IHC_RST_ZERO;
        end
        else
        begin
            state_ff <= nxt_state;
            en_ff <= nxt_en;
            busy_ff <= nxt_busy;
            cfg_ff <= nxt_cfg;
            gain_ff <= nxt_gain;
            rgn_ff <= nxt_rgn;
            raddr_ff <= nxt_raddr;
            loff_ff <= nxt_loff;
            fsize_ff <= nxt_fsize;
            act_loff_ff <= nxt_act_loff;
            line_base_ff <= nxt_line_base;
            rd_addr_ff <= nxt_rd_addr;
            req_ff <= nxt_req;
            x_ff <= nxt_x;
            y_ff <= nxt_y;
            drain_ff <= nxt_drain;
            dma_ff <= nxt_dma;
            irq_ff <= nxt_irq;
            prdata_ff <= nxt_prdata;
        end
    end

    // ------------------------------------------------------------------
    // pixel pipeline: input capture, then gain, shift and region match
    // ------------------------------------------------------------------
    logic in_vld_ff, nxt_in_vld;
    logic [IHC_PIX_W-1:0] in_pix_ff, nxt_in_pix;
    logic [15:0] in_x_ff, nxt_in_x;
    logic [15:0] in_y_ff, nxt_in_y;
    logic [IHC_NUM_RGN-1:0] hit_ff, nxt_hit;
    logic [IHC_NUM_RGN-1:0][IHC_BIN_AW-1:0] addr_ff, nxt_addr;
    logic [7:0] gain_sel;
    logic [23:0] prod;
    logic [23:0] shifted;
    logic [IHC_BIN_AW-1:0] bin_max;
    logic [IHC_BIN_AW-1:0] bin_idx;
    logic [2:0] rgn_used;
    logic [3:0] bins_log;
    logic [1:0] cpos;

    always_comb
    begin
        nxt_in_vld = 1'b0;
        nxt_in_pix = in_pix_ff;
        nxt_in_x = in_x_ff;
        nxt_in_y = in_y_ff;
        if ((state_ff == IHC_ST_STREAM) && i_vp_valid && !i_vp_eof)
        begin
            nxt_in_vld = 1'b1;
            nxt_in_pix = i_vp_data;
            nxt_in_x = x_ff;
            nxt_in_y = y_ff;
        end
        else if ((state_ff == IHC_ST_FETCH) && i_mem_rd_valid)
        begin
            nxt_in_vld = 1'b1;
            nxt_in_pix = cfg_ff[IHC_CFG_PW_BIT] ? {8'h00, i_mem_rd_data[7:0]} : i_mem_rd_data;
            nxt_in_x = x_ff;
            nxt_in_y = y_ff;
        end

        // gain by colour position, then shift and clamp to the top bin
        cpos = {in_y_ff[0], in_x_ff[0]} ^ cfg_ff[IHC_CFG_CFA_LSB +: 2];
        gain_sel = gain_ff[8 * cpos +: 8];
        prod = (24'(in_pix_ff) * 24'(gain_sel)) >> IHC_GAIN_FRAC;
        shifted = prod >> cfg_ff[IHC_CFG_SHIFT_LSB +: 4];
        bins_log = 4'(IHC_MIN_BINS_LOG) + 4'(cfg_ff[IHC_CFG_BINS_LSB +: 2]);
        bin_max = 8'((9'h001 << bins_log) - 9'h001);
        bin_idx = (shifted > 24'(bin_max)) ? bin_max : shifted[IHC_BIN_AW-1:0];
        case (cfg_ff[IHC_CFG_BINS_LSB +: 2])
            2'h3: rgn_used = 3'h1;
            2'h2: rgn_used = 3'h2;
            default: rgn_used = 3'h4;
        endcase
        // every region in use holding the pixel counts it; stride of 64 or more keeps regions in separate banks
        for (int r = 0; r < IHC_NUM_RGN; r++)
        begin
            nxt_hit[r] = in_vld_ff && (r < rgn_used)
                && (in_x_ff >= rgn_ff[2*r][15:0]) && (in_x_ff <= rgn_ff[2*r][31:16])
                && (in_y_ff >= rgn_ff[2*r+1][15:0]) && (in_y_ff <= rgn_ff[2*r+1][31:16]);
            nxt_addr[r] = 8'(r << ((bins_log > 4'h6) ? bins_log : 4'h6)) | bin_idx;
        end
    end

    // register stage of the pixel pipeline
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            in_vld_ff <= 1'b0;
            in_pix_ff <= '0;
            in_x_ff <= '0;
            in_y_ff <= '0;
            hit_ff <= '0;
            addr_ff <= '0;
        end
        else
        begin
            in_vld_ff <= nxt_in_vld;
            in_pix_ff <= nxt_in_pix;
            in_x_ff <= nxt_in_x;
            in_y_ff <= nxt_in_y;
            hit_ff <= nxt_hit;
            addr_ff <= nxt_addr;
        end
    end

    // ------------------------------------------------------------------
    // bin memory hookup; processor access gated while counting
    // ------------------------------------------------------------------
    assign bin.acc_hit = hit_ff;
    assign bin.acc_addr = addr_ff;
    assign bin.cpu_addr = i_paddr[IHC_BIN_AW+1:2];
    assign bin.cpu_wr = apb_wr & bin_sel & ~bin_block;
    assign bin.cpu_clr = car_read;
    assign bin.cpu_wdata = i_pwdata[IHC_CNT_W-1:0];

    ihc_bin_mem u_bin_mem (
        .i_clk_sys(i_clk_sys),
        .bin(bin.mem)
    );

    assign o_prdata = prdata_ff;
    assign o_mem_rd_req = req_ff;
    assign o_mem_rd_addr = rd_addr_ff;
    assign o_busy = busy_ff;
    assign o_dma_event = dma_ff;
    assign o_frame_irq = irq_ff;

endmodule // ihc_hist_ctrl

// ---- testbench/ihc_hist_chk.sv ----
// port assertions for histogram control
`timescale 1ns/1ps
module ihc_hist_chk
    import ihc_pkg::*;
(
    input logic i_clk_sys,
    input logic i_rst_n,
    input logic i_psel,
    input logic i_penable,
    input logic i_pwrite,
    input logic [11:0] i_paddr,
    input logic [31:0] i_pwdata,
    input logic [31:0] o_prdata,
    input logic o_pready,
    input logic o_pslverr,
    input logic i_vp_sof,
    input logic o_mem_rd_req,
    input logic o_busy,
    input logic o_dma_event,
    input logic o_frame_irq
);
    // ------------------------------------------------------------------
    // properties, one clock domain
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    a_zero_wait: assert property (o_pready == i_penable) else $error("pready not penable");
    a_no_bus_err: assert property (o_pslverr == 1'b0) else $error("pslverr high");
    a_busy_start: assert property ($rose(o_busy) |-> $past(i_vp_sof) || o_mem_rd_req)
        else $error("busy rose without start");
    a_mem_start: assert property ($rose(o_busy) && o_mem_rd_req |->
        $past(i_psel && i_penable && i_pwrite && i_paddr == IHC_OFF_CTRL && i_pwdata[0], 2))
        else $error("fetch without enable");
    a_fetch_busy: assert property (o_mem_rd_req |-> o_busy) else $error("fetch not busy");
    a_dma_at_clr: assert property ($fell(o_busy) |-> o_dma_event) else $error("busy fell without dma");
    a_dma_pulse: assert property (o_dma_event |-> !o_busy ##1 !o_dma_event) else $error("dma not one pulse");
    a_irq_late: assert property (o_dma_event |-> ##3 o_frame_irq) else $error("irq not 3 after dma");
    a_irq_cause: assert property (o_frame_irq |-> $past(o_dma_event, 3)) else $error("irq without dma");
    a_bin_block: assert property (o_busy && i_psel && !i_penable && !i_pwrite && i_paddr[11:10] == IHC_BIN_WIN
        |=> o_prdata == 32'h0000_0000) else $error("bin read not blocked");
endmodule // ihc_hist_chk

bind ihc_hist_ctrl ihc_hist_chk i_chk (.i_clk_sys, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_vp_sof, .o_mem_rd_req, .o_busy, .o_dma_event, .o_frame_irq);

// ---- testbench/ihc_mem_model.sv ----
// external memory model for pixel fetches
`timescale 1ns/1ps
module ihc_mem_model (
    input logic i_clk_sys,
    input logic i_req,
    input logic [31:0] i_addr,
    output logic o_valid,
    output logic [15:0] o_data
);
    int seed = 56140;
    // random stall per word; data inverts after the pulse
    initial
    begin
        o_valid = 1'b0;
        o_data = 16'h0000;
        forever
        begin
            @(posedge i_clk_sys);
            if (i_req === 1'b1)
            begin
                repeat (3 + {$random(seed)} % 4) @(posedge i_clk_sys);
                o_valid <= 1'b1;
                o_data <= {~i_addr[7:0], i_addr[7:0]}; // upper byte unused in 8-bit mode
                @(posedge i_clk_sys);
                o_valid <= 1'b0;
                o_data <= ~o_data;
            end
        end
    end
endmodule // ihc_mem_model

// ---- testbench/ihc_hist_ctrl_tb.sv ----
// self-checking bench for histogram control
`timescale 1ns/1ps
module ihc_hist_ctrl_tb;
    import ihc_pkg::*;
    logic clk, rst_n, psel, pen, pwr, sof, eol, eof, vval, mval, pready, req, busy, dma, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, maddr;
    logic [15:0] vdat, mdat;
    logic [31:0] exp_q[$];
    int n_errors = 0, cmp_count = 0, n_dma = 0, seed = 56140;
    ihc_hist_ctrl i_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(), .i_vp_sof(sof),
        .i_vp_eol(eol), .i_vp_eof(eof), .i_vp_valid(vval), .i_vp_data(vdat), .o_mem_rd_req(req),
        .o_mem_rd_addr(maddr), .i_mem_rd_valid(mval), .i_mem_rd_data(mdat), .o_busy(busy),
        .o_dma_event(dma), .o_frame_irq(irq));
    ihc_mem_model i_mem (.i_clk_sys(clk), .i_req(req), .i_addr(maddr), .o_valid(mval), .o_data(mdat));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ------------------------------------------------------------------
    // bus and stream tasks
    // ------------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {psel, pen} <= 2'b00;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic wait_irq;
        for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk);
        check("irq", 32'(irq), 32'h1);
    endtask
    task automatic rgns; // 2x2 windows
        for (int r = 0; r < 8; r++) apb(1'b1, IHC_OFF_RGN + 12'(4 * r), 32'h0001_0000);
    endtask
    task automatic pulse(input logic [2:0] m);
        @(posedge clk);
        {sof, eol, eof} <= m;
        @(posedge clk);
        {sof, eol, eof} <= 3'b000;
    endtask
    task automatic vlines; // 2x2 pixels, then frame end
        for (int y = 0; y < 2; y++)
        begin
            for (int x = 0; x < 2; x++)
            begin
                @(posedge clk);
                vval <= 1'b1;
                vdat <= 16'($random(seed));
            end
            @(posedge clk);
            vval <= 1'b0;
            pulse(3'b010);
        end
        pulse(3'b001);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // monitor: read data against oldest note, dma count
    // ------------------------------------------------------------------
    always @(posedge clk)
    begin
        if (psel && pen && !pwr && pready === 1'b1)
            check("prdata", prdata, exp_q.pop_front());
        if (dma === 1'b1)
            n_dma++;
    end
    // hang guard, far above the test length
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        close_out();
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {rst_n, psel, pen, pwr, sof, eol, eof, vval, paddr, pwdata, vdat} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(IHC_OFF_CFG, IHC_RST_ZERO);
        rd(IHC_OFF_GAIN, IHC_RST_GAIN);
        rd(12'h100, 32'h0000_0000);
        $display("reset values done");
        apb(1'b1, IHC_OFF_CFG, 32'h0000_0619);
        rgns();
        apb(1'b1, IHC_OFF_RADDR, 32'h0000_0040);
        apb(1'b1, IHC_OFF_LOFF, 32'h0000_0020);
        apb(1'b1, IHC_OFF_FSIZE, 32'h0002_0002);
        for (int i = 0; i < 4; i++) apb(1'b1, 12'h500 + 12'(4 * i[0] + 128 * i[1]), 32'h0);
        for (int f = 0; f < 2; f++)
        begin
            apb(1'b1, IHC_OFF_CTRL, 32'h0000_0001);
            apb(1'b1, IHC_OFF_CFG, 32'h0000_0000);
            rd(IHC_OFF_CTRL, 32'h0000_0002);
            rd(12'h500, 32'h0000_0000);
            wait_irq();
            rd(IHC_OFF_CFG, 32'h0000_0619);
            rd(12'h504 - 12'(4 * f), 32'(1 + f));
            rd(12'h504 - 12'(4 * f), 32'h0000_0000);
        end
        $display("memory frames done");
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(12'h580, 32'h0000_0002);
        rd(IHC_OFF_CFG, IHC_RST_ZERO);
        $display("reset retention done");
        rgns();
        pulse(3'b100);
        rd(IHC_OFF_CTRL, 32'h0000_0000);
        apb(1'b1, IHC_OFF_CTRL, 32'h0000_0001);
        pulse(3'b100);
        rd(IHC_OFF_CTRL, 32'h0000_0003);
        apb(1'b1, IHC_OFF_CTRL, 32'h0000_0000);
        rd(IHC_OFF_CTRL, 32'h0000_0002);
        vlines();
        wait_irq();
        rd(IHC_OFF_CTRL, 32'h0000_0000);
        pulse(3'b100);
        rd(IHC_OFF_CTRL, 32'h0000_0000);
        check("dma count", 32'(n_dma), 32'h3);
        $display("video frames done");
        close_out();
    end
endmodule // ihc_hist_ctrl_tb
